// *** pkg/seq_cfg_pkg.sv ***
package seq_cfg_pkg;

    // Clock and configuration load timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned LOAD_DELAY_NS = 3_500_000;
    localparam int unsigned LOAD_CYC      = LOAD_DELAY_NS / CLK_PERIOD_NS;

    // Slave address pattern and word length
    localparam logic [3:0] DEV_PATTERN = 4'hA;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;

    // Command codes and ranges
    localparam logic [7:0] REG_LAST    = 8'h45;
    localparam logic [7:0] CMD_EE_CFG  = 8'h80;
    localparam logic [7:0] CMD_EE_USR1 = 8'h81;
    localparam logic [7:0] CMD_EE_USR2 = 8'h82;
    localparam logic [7:0] CMD_BLK_RD  = 8'h84;
    localparam logic [7:0] CMD_REBOOT  = 8'h88;
    localparam logic [7:0] SPACE_REG   = 8'h00;

    typedef enum logic [9:0] {
        ST_IDLE   = 10'h001,
        ST_ADDR   = 10'h002,
        ST_ACK_A  = 10'h004,
        ST_CMD    = 10'h008,
        ST_ACK_C  = 10'h010,
        ST_DATA   = 10'h020,
        ST_ACK_D  = 10'h040,
        ST_TX     = 10'h080,
        ST_TX_ACK = 10'h100,
        ST_IGNORE = 10'h200
    } slv_state_t;

    // Write toward the register bank or the EEPROM
    typedef struct packed {
        logic       valid;
        logic       to_eeprom;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] data;
    } wr_req_t;

endpackage : seq_cfg_pkg

// *** design/load_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Holds busy for a fixed count after reset or after a restart pulse
module load_timer #(
    parameter int unsigned CYCLES = 35000
) (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    output logic      busy_o
);

    localparam logic [15:0] LOAD_VAL = 16'(CYCLES);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (start_i) begin
            cnt_nxt = LOAD_VAL;
        end else if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_r <= LOAD_VAL;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy_o = (cnt_r != 16'h0000);

endmodule : load_timer

`default_nettype wire

// *** design/sequencer_config_serial_slave.sv ***
//Behaviour
//- Sent byte 88h reloads configuration from storage
//- Reload delay after reboot equals power-up delay
//- Slave only; master drives clock, up to 400kHz
//- Words are 8 bits plus ninth acknowledge
//- Data change during clock high is condition
//- Start falls, stop rises, both clock high
//- Stop honoured anywhere; start and stop separated
//- Read after command needs repeated start
//- Ack accepted bytes by holding data low
//- Release data on ninth clock when transmitting
//- No address ack while loading or EEPROM busy
//- Upper address bits 1010, bit one ignored
//- Next two address bits match strap pins
//- Address LSB zero writes, one reads
//- Sent byte loads pointer; bad address refused
//- 80h-82h acked, expect more; stop keeps pointer
//- 84h arms block read before repeated start
//- Register write codes 00h-45h store data
//- Invalid command code gets no ack
//- Second data byte acked before stop
//- 80h configuration space; 81h, 82h user space
//- Data range 00h-45h for 80h, any otherwise
`timescale 1ns/1ps
`default_nettype none

module sequencer_config_serial_slave
    import seq_cfg_pkg::*;
#(
    parameter int unsigned LOAD_CYCLES = LOAD_CYC
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Two-wire bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Strapped address pins
    input  wire logic       addr_strap_low_i,
    input  wire logic       addr_strap_high_i,
    // Storage status and read data
    input  wire logic       ee_busy_i,
    input  wire logic [7:0] rd_data_i,
    // Device side
    output wr_req_t         wr_o,
    output logic [7:0]      ptr_hi_o,
    output logic [7:0]      ptr_lo_o,
    output logic            blk_rd_armed_o,
    output logic            rd_next_o,
    output logic            reboot_o,
    output logic            loading_o
);

    slv_state_t  state_r,  state_nxt;
    logic [7:0]  shift_r,  shift_nxt;
    logic [3:0]  cnt_r,    cnt_nxt;
    logic        ack_r,    ack_nxt;
    logic [7:0]  cmd_r,    cmd_nxt;
    logic [1:0]  dcnt_r,   dcnt_nxt;
    logic [7:0]  phi_r,    phi_nxt;
    logic [7:0]  plo_r,    plo_nxt;
    logic        armed_r,  armed_nxt;
    logic        rbp_r,    rbp_nxt;
    logic        oe_r,     oe_nxt;
    logic        rdn_r,    rdn_nxt;
    logic        rbt_r,    rbt_nxt;
    wr_req_t     wr_r,     wr_nxt;
    logic        scl_q,    sda_q;

    logic start_c, stop_c, rise_c, fall_c, done_c;
    logic addr_match, addr_ok, cmd_valid, cmd_reg, cmd_ee;
    logic [7:0] next_reg;

    // Bus conditions from the previous sample
    assign start_c = scl_q & scl_i & sda_q & ~sda_i;
    assign stop_c  = scl_q & scl_i & ~sda_q & sda_i;
    assign rise_c  = ~scl_q & scl_i;
    assign fall_c  = scl_q & ~scl_i;
    assign done_c  = fall_c & (cnt_r == BITS_PER_WORD);

    assign addr_match = (shift_r[7:4] == DEV_PATTERN)
                      && (shift_r[3] == addr_strap_high_i)
                      && (shift_r[2] == addr_strap_low_i);
    assign addr_ok   = addr_match && !loading_o && !ee_busy_i;
    assign cmd_reg   = (shift_r <= REG_LAST);
    assign cmd_ee    = (cmd_r == CMD_EE_CFG) || (cmd_r == CMD_EE_USR1)
                     || (cmd_r == CMD_EE_USR2);
    assign cmd_valid = cmd_reg || (shift_r == CMD_EE_CFG)
                     || (shift_r == CMD_EE_USR1)
                     || (shift_r == CMD_EE_USR2)
                     || (shift_r == CMD_BLK_RD)
                     || (shift_r == CMD_REBOOT);
    assign next_reg  = (cmd_r < REG_LAST) ? cmd_r + 8'h01 : REG_LAST;

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        ack_nxt   = ack_r;
        cmd_nxt   = cmd_r;
        dcnt_nxt  = dcnt_r;
        phi_nxt   = phi_r;
        plo_nxt   = plo_r;
        armed_nxt = armed_r;
        rbp_nxt   = rbp_r;
        rdn_nxt   = 1'b0;
        rbt_nxt   = 1'b0;
        wr_nxt    = '0;
        if (stop_c) begin
            state_nxt = ST_IDLE;
            rbt_nxt   = rbp_r;
            rbp_nxt   = 1'b0;
        end else if (start_c) begin
            state_nxt = ST_ADDR;
            cnt_nxt   = 4'h0;
            rbp_nxt   = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_IGNORE: begin
                    state_nxt = state_r;
                end
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (rise_c) begin
                        shift_nxt = {shift_r[6:0], sda_i};
                        cnt_nxt   = cnt_r + 4'h1;
                    end else if (done_c) begin
                        cnt_nxt   = 4'h0;
                        state_nxt = ST_IGNORE;
                        if (state_r == ST_ADDR) begin
                            if (addr_ok) begin
                                state_nxt = ST_ACK_A;
                                ack_nxt   = shift_r[0];
                            end
                        end else if (state_r == ST_CMD) begin
                            if (cmd_valid) begin
                                state_nxt = ST_ACK_C;
                                cmd_nxt   = shift_r;
                                dcnt_nxt  = 2'd0;
                                if (cmd_reg) begin
                                    phi_nxt = SPACE_REG;
                                    plo_nxt = shift_r;
                                end
                                if (shift_r == CMD_BLK_RD) begin
                                    armed_nxt = 1'b1;
                                end
                                rbp_nxt = (shift_r == CMD_REBOOT);
                            end
                        end else begin
                            rbp_nxt  = 1'b0;
                            dcnt_nxt = dcnt_r + 2'd1;
                            if (cmd_r <= REG_LAST && dcnt_r < 2'd2) begin
                                state_nxt      = ST_ACK_D;
                                wr_nxt.valid   = 1'b1;
                                wr_nxt.addr_hi = SPACE_REG;
                                wr_nxt.addr_lo = (dcnt_r == 2'd0)
                                               ? cmd_r : next_reg;
                                wr_nxt.data    = shift_r;
                            end else if (cmd_ee && dcnt_r == 2'd0) begin
                                if (cmd_r != CMD_EE_CFG
                                    || shift_r <= REG_LAST) begin
                                    state_nxt = ST_ACK_D;
                                    phi_nxt   = cmd_r;
                                    plo_nxt   = shift_r;
                                end
                            end else if (cmd_ee && dcnt_r == 2'd1) begin
                                state_nxt        = ST_ACK_D;
                                wr_nxt.valid     = 1'b1;
                                wr_nxt.to_eeprom = 1'b1;
                                wr_nxt.addr_hi   = phi_r;
                                wr_nxt.addr_lo   = plo_r;
                                wr_nxt.data      = shift_r;
                            end
                        end
                    end
                end
                ST_ACK_A: begin
                    if (fall_c) begin
                        if (ack_r) begin
                            state_nxt = ST_TX;
                            shift_nxt = rd_data_i;
                            rdn_nxt   = 1'b1;
                            armed_nxt = 1'b0;
                        end else begin
                            state_nxt = ST_CMD;
                        end
                    end
                end
                ST_ACK_C, ST_ACK_D: begin
                    if (fall_c) begin
                        state_nxt = ST_DATA;
                    end
                end
                ST_TX: begin
                    if (rise_c) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (done_c) begin
                        state_nxt = ST_TX_ACK;
                        cnt_nxt   = 4'h0;
                    end else if (fall_c) begin
                        shift_nxt = {shift_r[6:0], 1'b1};
                    end
                end
                ST_TX_ACK: begin
                    if (rise_c) begin
                        ack_nxt = ~sda_i;
                    end else if (fall_c) begin
                        if (ack_r) begin
                            state_nxt = ST_TX;
                            shift_nxt = rd_data_i;
                            rdn_nxt   = 1'b1;
                        end else begin
                            state_nxt = ST_IGNORE;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Line is pulled low only in ack slots or for a transmitted zero
    always_comb begin
        oe_nxt = 1'b0;
        if (state_nxt == ST_ACK_A || state_nxt == ST_ACK_C
            || state_nxt == ST_ACK_D) begin
            oe_nxt = 1'b1;
        end else if (state_nxt == ST_TX) begin
            oe_nxt = ~shift_nxt[7];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            cnt_r   <= 4'h0;
            ack_r   <= 1'b0;
            cmd_r   <= 8'h00;
            dcnt_r  <= 2'd0;
            phi_r   <= 8'h00;
            plo_r   <= 8'h00;
            armed_r <= 1'b0;
            rbp_r   <= 1'b0;
            oe_r    <= 1'b0;
            rdn_r   <= 1'b0;
            rbt_r   <= 1'b0;
            wr_r    <= '0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            ack_r   <= ack_nxt;
            cmd_r   <= cmd_nxt;
            dcnt_r  <= dcnt_nxt;
            phi_r   <= phi_nxt;
            plo_r   <= plo_nxt;
            armed_r <= armed_nxt;
            rbp_r   <= rbp_nxt;
            oe_r    <= oe_nxt;
            rdn_r   <= rdn_nxt;
            rbt_r   <= rbt_nxt;
            wr_r    <= wr_nxt;
            scl_q   <= scl_i;
            sda_q   <= sda_i;
        end
    end

    load_timer #(
        .CYCLES (LOAD_CYCLES)
    ) u_load (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .start_i (rbt_r),
        .busy_o  (loading_o)
    );

    // Open-drain data; clock is never driven
    assign sda_o          = 1'b0;
    assign sda_oe_o       = oe_r;
    assign wr_o           = wr_r;
    assign ptr_hi_o       = phi_r;
    assign ptr_lo_o       = plo_r;
    assign blk_rd_armed_o = armed_r;
    assign rd_next_o      = rdn_r;
    assign reboot_o       = rbt_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_byte_end(slv_state_t st);
        state_r == st && done_c && !stop_c && !start_c;
    endsequence

    chk_start_addr: assert property (start_c |=> state_r == ST_ADDR)
        else $error("start did not begin address phase");
    chk_stop_idle: assert property (stop_c |=> state_r == ST_IDLE)
        else $error("stop not honoured");
    chk_addr_pattern: assert property (s_byte_end(ST_ADDR)
        ##0 shift_r[7:4] != 4'hA |=> state_r == ST_IGNORE && !sda_oe_o)
        else $error("foreign pattern acknowledged");
    chk_strap_match: assert property (s_byte_end(ST_ADDR)
        ##0 shift_r[3:2] != {addr_strap_high_i, addr_strap_low_i}
        |=> !sda_oe_o) else $error("strap mismatch acknowledged");
    chk_busy_nack: assert property (s_byte_end(ST_ADDR)
        ##0 (loading_o || ee_busy_i) |=> state_r != ST_ACK_A && !sda_oe_o)
        else $error("address acked while busy");
    chk_reboot_load: assert property (reboot_o |=> loading_o [*8])
        else $error("reboot without load delay");
    chk_bad_cmd: assert property (s_byte_end(ST_CMD)
        ##0 !(shift_r inside {[8'h00:8'h45], [8'h80:8'h82], 8'h84, 8'h88})
        |=> state_r == ST_IGNORE) else $error("invalid command acked");
    chk_cfg_range: assert property (s_byte_end(ST_DATA)
        ##0 cmd_r == 8'h80 && dcnt_r == 2'd0 && shift_r > 8'h45
        |=> !sda_oe_o) else $error("config pointer out of range acked");
    chk_reg_range: assert property (wr_o.valid && !wr_o.to_eeprom
        |-> wr_o.addr_lo <= 8'h45) else $error("register write beyond bank");
    chk_tx_release: assert property (state_r == ST_TX_ACK
        |-> !sda_oe_o) else $error("line held during master ack");
    chk_ignore_quiet: assert property (state_r == ST_IGNORE
        |-> !sda_oe_o) else $error("line driven while ignoring");
    chk_ack_hold: assert property ($rose(state_r == ST_ACK_C)
        |-> sda_oe_o [*2]) else $error("ack not held low");

endmodule : sequencer_config_serial_slave

`default_nettype wire

// *** test/bus_master.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behavioural bus master: owns the bus clock and only ever pulls data low
module bus_master #(
    parameter int unsigned HALF = 12
) (
    // Clock
    input  wire logic mclk_i,
    // Bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    logic sda_seen;

    initial begin
        scl_o      = 1'h1;
        sda_pull_o = 1'h0;
    end

    // Sample the wire half a cycle away from the slave's update edge
    always @(negedge mclk_i) begin
        sda_seen <= sda_i;
    end

    task automatic step(input logic clk, input logic pull);
        scl_o      <= clk;
        sda_pull_o <= pull;
        repeat (HALF) @(posedge mclk_i);
    endtask : step

    task automatic start();
        step(scl_o, 1'h0);
        step(1'h1, 1'h0);
        step(1'h1, 1'h1);
        step(1'h0, 1'h1);
    endtask : start

    task automatic stop();
        step(1'h0, 1'h1);
        step(1'h1, 1'h1);
        step(1'h1, 1'h0);
    endtask : stop

    // Fewer than eight bits leaves the byte unfinished for an early stop
    task automatic wr_byte(input logic [7:0] b, input int n, output logic ack);
        ack = 1'h0;
        for (int i = 7; i > 7 - n; i--) begin
            step(1'h0, ~b[i]);
            step(1'h1, ~b[i]);
            step(1'h0, ~b[i]);
        end
        if (n == 8) begin
            step(1'h0, 1'h0);
            step(1'h1, 1'h0);
            ack = ~sda_seen;
            step(1'h0, 1'h0);
        end
    endtask : wr_byte

    task automatic rd_byte(input logic mack, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            step(1'h0, 1'h0);
            step(1'h1, 1'h0);
            b = {b[6:0], sda_seen};
            step(1'h0, 1'h0);
        end
        step(1'h0, mack);
        step(1'h1, mack);
        step(1'h0, mack);
    endtask : rd_byte
endmodule : bus_master

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench
    import seq_cfg_pkg::*;
;
    localparam int LC    = 600;
    localparam int LIMIT = 50000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  cmd;
        logic [1:0]  nd;
        logic [7:0]  d1;
        logic [7:0]  d2;
        logic [3:0]  acks;
        logic [15:0] ptr;
        wr_req_t     wr;
    } row_t;

    // Ack bits: address, command, data 1, data 2; wr is the last write seen
    localparam row_t ROWS [0:13] = '{
        '{8'hA4, 8'h10, 2'h1, 8'h5A, 8'h00, 4'hE, 16'h0010, 26'h200105A},
        '{8'hA6, 8'h45, 2'h2, 8'h11, 8'h22, 4'hF, 16'h0045, 26'h2004522},
        '{8'hA4, 8'h46, 2'h0, 8'h00, 8'h00, 4'h8, 16'h0045, 26'h0},
        '{8'hA4, 8'h80, 2'h1, 8'h45, 8'h00, 4'hE, 16'h8045, 26'h0},
        '{8'hA4, 8'h80, 2'h1, 8'h46, 8'h00, 4'hC, 16'h8045, 26'h0},
        '{8'hA4, 8'h81, 2'h2, 8'hFF, 8'h3C, 4'hF, 16'h81FF, 26'h381FF3C},
        '{8'hA4, 8'h82, 2'h1, 8'h00, 8'h00, 4'hE, 16'h8200, 26'h0},
        '{8'hA4, 8'h83, 2'h0, 8'h00, 8'h00, 4'h8, 16'h8200, 26'h0},
        '{8'hA8, 8'h10, 2'h1, 8'h77, 8'h00, 4'h0, 16'h8200, 26'h0},
        '{8'hB4, 8'h10, 2'h0, 8'h00, 8'h00, 4'h0, 16'h8200, 26'h0},
        '{8'hA4, 8'h81, 2'h0, 8'h00, 8'h00, 4'hC, 16'h8200, 26'h0},
        '{8'hA4, 8'h88, 2'h1, 8'h00, 8'h00, 4'hC, 16'h8200, 26'h0},
        '{8'hA4, 8'h20, 2'h0, 8'h00, 8'h00, 4'hC, 16'h0020, 26'h0},
        '{8'hA4, 8'h82, 2'h2, 8'h10, 8'h99, 4'hF, 16'h8210, 26'h3821099}
    };
    localparam row_t NAK_ROW = '{8'hA4, 8'h10, 2'h1, 8'h5A, 8'h00, 4'h0,
                                 16'h0000, 26'h0};
    localparam row_t RB_ROW  = '{8'hA4, 8'h88, 2'h0, 8'h00, 8'h00, 4'hC,
                                 16'h0000, 26'h0};

    logic       mclk = 1'h0;
    logic       rst;
    logic       scl;
    logic       m_pull;
    wire        sda;
    logic       sda_out;
    logic       sda_oe;
    logic       strap_lo;
    logic       strap_hi;
    logic       ee_busy;
    logic [7:0] rd_data = 8'hC3;
    wr_req_t    wr;
    wr_req_t    got_wr;
    logic [7:0] ptr_hi;
    logic [7:0] ptr_lo;
    logic       armed;
    logic       rd_next;
    logic       reboot;
    logic       loading;
    logic       load_q = 1'h1;
    logic [7:0] reboot_cnt = 8'h00;
    logic [7:0] rd_cnt = 8'h00;
    logic [7:0] wr_cnt = 8'h00;
    int         cyc = 0;
    int         reboot_at = 0;
    int         load_end = 0;
    int         fail_count = 0;
    int         checks_done = 0;

    // Open-drain wire with pull-up
    assign sda = ~(m_pull | (sda_oe & ~sda_out));

    always #50 mclk = ~mclk;

    sequencer_config_serial_slave #(
        .LOAD_CYCLES(LC)
    ) i_dut (
        .mclk_i           (mclk),
        .rst_i            (rst),
        .scl_i            (scl),
        .sda_i            (sda),
        .sda_o            (sda_out),
        .sda_oe_o         (sda_oe),
        .addr_strap_low_i (strap_lo),
        .addr_strap_high_i(strap_hi),
        .ee_busy_i        (ee_busy),
        .rd_data_i        (rd_data),
        .wr_o             (wr),
        .ptr_hi_o         (ptr_hi),
        .ptr_lo_o         (ptr_lo),
        .blk_rd_armed_o   (armed),
        .rd_next_o        (rd_next),
        .reboot_o         (reboot),
        .loading_o        (loading)
    );

    bus_master #(.HALF(12)) i_master (
        .mclk_i    (mclk),
        .sda_i     (sda),
        .scl_o     (scl),
        .sda_pull_o(m_pull)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // Pulses are caught here; the next read byte differs from the last
    always @(posedge mclk) begin
        cyc    <= cyc + 1;
        load_q <= loading;
        if (wr.valid === 1'h1) begin
            got_wr <= wr;
            wr_cnt <= wr_cnt + 8'h01;
        end
        if (reboot === 1'h1) begin
            reboot_cnt <= reboot_cnt + 8'h01;
            reboot_at  <= cyc;
        end
        if (load_q === 1'h1 && loading === 1'h0) load_end <= cyc;
        if (rd_next === 1'h1) begin
            rd_cnt  <= rd_cnt + 8'h01;
            rd_data <= ~rd_data;
        end
    end

    task automatic chk_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_bit

    task automatic chk_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_byte

    task automatic chk_wr(input string what, input wr_req_t e,
                          input wr_req_t g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_wr

    // Every byte is sent whatever the answer, so refusals must stick
    task automatic run_row(input row_t r);
        logic [3:0] got;
        logic [7:0] wr_base;
        got     = 4'h0;
        wr_base = wr_cnt;
        i_master.start();
        i_master.wr_byte(r.addr, 8, got[3]);
        i_master.wr_byte(r.cmd, 8, got[2]);
        if (r.nd > 2'h0) i_master.wr_byte(r.d1, 8, got[1]);
        if (r.nd > 2'h1) i_master.wr_byte(r.d2, 8, got[0]);
        i_master.stop();
        chk_byte("acks", {4'h0, r.acks}, {4'h0, got});
        chk_wr("write", r.wr, (wr_cnt == wr_base) ? '0 : got_wr);
    endtask : run_row

    task automatic wait_loaded();
        for (int i = 0; i < 2 * LC && loading !== 1'h0; i++) @(posedge mclk);
        chk_bit("loading", 1'h0, loading);
    endtask : wait_loaded

    initial begin
        logic       a;
        logic [7:0] b;
        int         len;
        // Cycle ceiling: a hang counts as a mismatch
        fork
            begin
                wait (cyc == LIMIT);
                fail_count++;
                complete_run();
            end
        join_none
        rst      = 1'h1;
        strap_lo = 1'h1;
        strap_hi = 1'h0;
        ee_busy  = 1'h0;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
        chk_bit("loading", 1'h1, loading);
        chk_bit("ack_drive", 1'h0, sda_oe);
        chk_byte("ptr_hi", 8'h00, ptr_hi);
        @(posedge mclk);
        run_row(NAK_ROW);
        wait_loaded();
        for (int i = 0; i < 14; i++) begin
            run_row(ROWS[i]);
            chk_byte("ptr_hi", ROWS[i].ptr[15:8], ptr_hi);
            chk_byte("ptr_lo", ROWS[i].ptr[7:0], ptr_lo);
        end
        // Swapped strap levels move the matching address
        strap_hi <= 1'h1;
        strap_lo <= 1'h0;
        i_master.start();
        i_master.wr_byte(8'hA8, 8, a);
        i_master.stop();
        chk_bit("strap_ack", 1'h1, a);
        i_master.start();
        i_master.wr_byte(8'hA4, 8, a);
        i_master.stop();
        chk_bit("strap_nak", 1'h0, a);
        strap_hi <= 1'h0;
        strap_lo <= 1'h1;
        run_row(RB_ROW);
        chk_bit("loading", 1'h1, loading);
        i_master.start();
        i_master.wr_byte(8'hA4, 8, a);
        i_master.stop();
        chk_bit("reboot_nak", 1'h0, a);
        wait_loaded();
        // load_end is written at the edge where the fall is seen
        @(posedge mclk);
        len = load_end - reboot_at;
        chk_bit("load_len", 1'h1, len >= LC && len <= LC + 3);
        chk_byte("reboot_cnt", 8'h01, reboot_cnt);
        ee_busy <= 1'h1;
        run_row(NAK_ROW);
        ee_busy <= 1'h0;
        i_master.start();
        i_master.wr_byte(8'hA4, 4, a);
        i_master.stop();
        run_row(ROWS[0]);
        i_master.start();
        i_master.wr_byte(8'hA4, 8, a);
        i_master.wr_byte(8'h84, 8, a);
        chk_bit("blk_ack", 1'h1, a);
        chk_bit("armed", 1'h1, armed);
        i_master.start();
        i_master.wr_byte(8'hA5, 8, a);
        chk_bit("rd_addr_ack", 1'h1, a);
        i_master.rd_byte(1'h1, b);
        chk_byte("rd_first", 8'hC3, b);
        chk_bit("armed", 1'h0, armed);
        i_master.rd_byte(1'h0, b);
        chk_byte("rd_second", 8'h3C, b);
        i_master.stop();
        chk_byte("rd_count", 8'h02, rd_cnt);
        complete_run();
    end
endmodule : testbench

`default_nettype wire
